/* hdl/sdrt_ctrl.v */
// Purpose: sdram auto-refresh scheduler and access timing controller
// Assumes: sdram clock is clk/2; one single-word access at a time
// Notes: registers on axi4-lite; sdram pins driven from flip-flops
// Function
// - Setting the refresh enable bit issues an auto-refresh at once.
// - After each auto-refresh only deselects go out for the wait count.
// - Auto-refresh repeats with the programmed interval count period.
// - Read data are waited for by the programmed cas latency.
// - Write recovery of one or two cycles precedes the precharge.
// - The next activate waits the programmed precharge period.
// - Activate to precharge keeps at least the programmed interval.
// - Read or write follows activate by the programmed delay.
// - Accesses use activate, read or write, all-bank precharge, deselect.
// - A write of the mode register sends a mode register set command.
`timescale 1ns/1ps
`include "sdrt_map.vh"
module sdrt_ctrl (
  // clock, reset, clock enable
  input wire clk,
  input wire rst,
  input wire ce,
  // axi4-lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // user access port
  input wire req_valid,
  input wire req_write,
  input wire [21:0] req_addr,
  input wire [15:0] req_wdata,
  output reg req_ack,
  output reg rd_valid,
  output reg [15:0] rd_data,
  // sdram pins
  output reg sd_clk,
  output reg sd_cke,
  output reg sd_cs_n,
  output reg sd_ras_n,
  output reg sd_cas_n,
  output reg sd_we_n,
  output reg [1:0] sd_ba,
  output reg [11:0] sd_addr,
  output reg [1:0] sd_dqm,
  input wire [15:0] sd_dq_in,
  output reg [15:0] sd_dq_out,
  output reg sd_dq_oe
);

localparam ST_IDLE = 3'h0;
localparam ST_RCDW = 3'h1;
localparam ST_CLW = 3'h2;
localparam ST_PREW = 3'h3;
localparam ST_WAIT = 3'h4;

// byte-lane merge of a bus write into a register image
function [31:0] lane_merge;
  input [31:0] old_v;
  input [31:0] new_v;
  input [3:0] strb;
  integer i;
  begin
    lane_merge = old_v;
    for (i = 0; i < 4; i = i + 1) begin
      if (strb[i]) begin
        lane_merge[8*i +: 8] = new_v[8*i +: 8];
      end
    end
  end
endfunction

// field value n means n + 1 cycles, so the down counter loads n itself
function [4:0] cnt_load;
  input [3:0] field;
  begin
    cnt_load = {1'b0, field};
  end
endfunction

function mapped;
  input [7:0] a;
  begin
    mapped = (a == `SDRT_OFS_REFEN) || (a == `SDRT_OFS_REFCTL) ||
             (a == `SDRT_OFS_TIMING) || (a == `SDRT_OFS_MODE) ||
             (a == `SDRT_OFS_STATUS);
  end
endfunction

// registers
reg ref_en_r;
reg [15:0] refctl_r;
reg [18:0] timing_r;
reg [14:0] mode_r;
reg aw_hold_r;
reg w_hold_r;
reg [7:0] aw_addr_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;
// engine state
reg [2:0] state_r;
reg [4:0] cnt_r;
reg [2:0] ras_cnt_r;
reg ref_pend_r;
reg mode_pend_r;
reg acc_write_r;
reg [7:0] acc_col_r;
reg [15:0] acc_data_r;
reg [15:0] dq_s1_r;
reg [15:0] dq_s2_r;

wire tick = sd_clk;
wire ref_due;
wire wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;
wire mode_hit = wr_go && (aw_addr_r == `SDRT_OFS_MODE) && (|w_strb_r);
wire mode_issue = tick && (state_r == ST_IDLE) && mode_pend_r;
wire ref_issue = tick && (state_r == ST_IDLE) && !mode_pend_r &&
                 ref_pend_r;

wire [2:0] f_cl = timing_r[`SDRT_CL_MSB:`SDRT_CL_LSB];
wire f_wr = timing_r[`SDRT_WR_BIT];
wire [2:0] f_rp = timing_r[`SDRT_RP_MSB:`SDRT_RP_LSB];
wire [1:0] f_rcd = timing_r[`SDRT_RCD_MSB:`SDRT_RCD_LSB];
wire [2:0] f_ras = timing_r[`SDRT_RAS_MSB:`SDRT_RAS_LSB];
wire [3:0] f_refresh_wait_cycles = refctl_r[`SDRT_REFRESH_WAIT_CYCLES_MSB:`SDRT_REFRESH_WAIT_CYCLES_LSB];
wire [31:0] wr_img_en = lane_merge({31'h0, ref_en_r}, w_data_r,
                                   w_strb_r);
wire [31:0] wr_img_ctl = lane_merge({16'h0, refctl_r}, w_data_r,
                                    w_strb_r);
wire [31:0] wr_img_tim = lane_merge({13'h0, timing_r}, w_data_r,
                                    w_strb_r);
wire [31:0] wr_img_mod = lane_merge({17'h0, mode_r}, w_data_r,
                                    w_strb_r);

sdrt_refresh_timer u_timer (
  .clk(clk),
  .rst(rst),
  .ce(ce),
  .tick(tick),
  .enable(ref_en_r),
  .interval(refctl_r[`SDRT_RFC_MSB:`SDRT_RFC_LSB]),
  .due(ref_due)
);

// axi4-lite slave: address and data may arrive in either order
always @(posedge clk or posedge rst) begin
  if (rst) begin
    s_axi_awready <= 1'b1;
    s_axi_wready <= 1'b1;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `SDRT_RESP_OKAY;
    s_axi_arready <= 1'b1;
    s_axi_rvalid <= 1'b0;
    s_axi_rresp <= `SDRT_RESP_OKAY;
    s_axi_rdata <= 32'h00000000;
    aw_hold_r <= 1'b0;
    w_hold_r <= 1'b0;
    aw_addr_r <= 8'h00;
    w_data_r <= 32'h00000000;
    w_strb_r <= 4'h0;
    ref_en_r <= `SDRT_RST_REFEN;
    refctl_r <= `SDRT_RST_REFCTL;
    timing_r <= `SDRT_RST_TIMING;
    mode_r <= `SDRT_RST_MODE;
  end else if (ce) begin
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      s_axi_awready <= 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    if (wr_go) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_addr_r) ? `SDRT_RESP_OKAY :
                     `SDRT_RESP_SLVERR;
      case (aw_addr_r)
        `SDRT_OFS_REFEN: ref_en_r <= wr_img_en[`SDRT_REFEN_BIT];
        `SDRT_OFS_REFCTL: refctl_r <= wr_img_ctl[15:0];
        `SDRT_OFS_TIMING: timing_r <= wr_img_tim[18:0];
        `SDRT_OFS_MODE: mode_r <= wr_img_mod[`SDRT_MODE_MSB:0];
        default: ref_en_r <= ref_en_r;
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped({s_axi_araddr[7:2], 2'b00}) ?
                     `SDRT_RESP_OKAY : `SDRT_RESP_SLVERR;
      case ({s_axi_araddr[7:2], 2'b00})
        `SDRT_OFS_REFEN: s_axi_rdata <= {31'h0, ref_en_r};
        `SDRT_OFS_REFCTL: s_axi_rdata <= {16'h0, refctl_r};
        `SDRT_OFS_TIMING: s_axi_rdata <= {13'h0, timing_r};
        `SDRT_OFS_MODE: s_axi_rdata <= {17'h0, mode_r};
        `SDRT_OFS_STATUS: s_axi_rdata <= {27'h0, ref_pend_r,
                                          mode_pend_r, state_r};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
end

// pending flags: a new set in the clearing cycle wins
always @(posedge clk or posedge rst) begin
  if (rst) begin
    ref_pend_r <= 1'b0;
    mode_pend_r <= 1'b0;
    dq_s1_r <= 16'h0000;
    dq_s2_r <= 16'h0000;
  end else if (ce) begin
    ref_pend_r <= (ref_pend_r & ~ref_issue) | ref_due;
    mode_pend_r <= (mode_pend_r & ~mode_issue) | mode_hit;
    dq_s1_r <= sd_dq_in;
    dq_s2_r <= dq_s1_r;
  end
end

// command engine, one step per sdram clock cycle
always @(posedge clk or posedge rst) begin
  if (rst) begin
    sd_clk <= 1'b0;
    sd_cke <= 1'b0;
    {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= `SDRT_CMD_DSL;
    sd_ba <= 2'h0;
    sd_addr <= 12'h000;
    sd_dqm <= 2'h0;
    sd_dq_out <= 16'h0000;
    sd_dq_oe <= 1'b0;
    state_r <= ST_IDLE;
    cnt_r <= 5'h00;
    ras_cnt_r <= 3'h0;
    acc_write_r <= 1'b0;
    acc_col_r <= 8'h00;
    acc_data_r <= 16'h0000;
    req_ack <= 1'b0;
    rd_valid <= 1'b0;
    rd_data <= 16'h0000;
  end else if (ce) begin
    // outputs change as sd_clk falls; the memory samples on its rise
    sd_clk <= ~sd_clk;
    sd_cke <= 1'b1;
    req_ack <= 1'b0;
    rd_valid <= 1'b0;
    if (tick) begin
      {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= `SDRT_CMD_DSL;
      sd_dq_oe <= 1'b0;
      if (ras_cnt_r != 3'h0) begin
        ras_cnt_r <= ras_cnt_r - 3'h1;
      end
      case (state_r)
        ST_IDLE: begin
          if (mode_pend_r) begin
            {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= `SDRT_CMD_MRS;
            sd_addr <= mode_r[11:0];
            sd_ba <= mode_r[13:12];
            cnt_r <= `SDRT_MRD_CYCLES - 5'h01;
            state_r <= ST_WAIT;
          end else if (ref_pend_r) begin
            {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= `SDRT_CMD_REF;
            cnt_r <= cnt_load(f_refresh_wait_cycles);
            state_r <= ST_WAIT;
          end else if (req_valid) begin
            {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= `SDRT_CMD_ACT;
            sd_ba <= req_addr[21:20];
            sd_addr <= req_addr[19:8];
            acc_write_r <= req_write;
            acc_col_r <= req_addr[7:0];
            acc_data_r <= req_wdata;
            req_ack <= 1'b1;
            ras_cnt_r <= f_ras;
            cnt_r <= cnt_load({2'b00, f_rcd});
            state_r <= ST_RCDW;
          end
        end
        ST_RCDW: begin
          if (cnt_r == 5'h00) begin
            sd_addr <= {4'h0, acc_col_r};
            if (acc_write_r) begin
              {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= `SDRT_CMD_WR;
              sd_dq_out <= acc_data_r;
              sd_dq_oe <= 1'b1;
              cnt_r <= {4'h0, f_wr};
              state_r <= ST_PREW;
            end else begin
              {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= `SDRT_CMD_RD;
              // one extra cycle covers the two-flop pin synchroniser
              cnt_r <= cnt_load({1'b0, f_cl}) + 5'h01;
              state_r <= ST_CLW;
            end
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        ST_CLW: begin
          if (cnt_r == 5'h00) begin
            rd_data <= dq_s2_r;
            rd_valid <= 1'b1;
            state_r <= ST_PREW;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        ST_PREW: begin
          if (cnt_r == 5'h00 && ras_cnt_r == 3'h0) begin
            {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} <= `SDRT_CMD_PRE;
            sd_addr <= 12'h400;
            cnt_r <= cnt_load({1'b0, f_rp});
            state_r <= ST_WAIT;
          end else if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        ST_WAIT: begin
          // deselects only; next command no earlier than the next idle
          if (cnt_r == 5'h00) begin
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
end

endmodule

/* hdl/sdrt_map.vh */
// Purpose: register map, field positions, reset values and timing counts
// Assumes: included by the refresh/timing controller files
// Notes: all counts are in sdram clock cycles unless named otherwise
`ifndef SDRT_MAP_VH
`define SDRT_MAP_VH

// register byte offsets on the axi4-lite bus
`define SDRT_OFS_REFEN 8'h00
`define SDRT_OFS_REFCTL 8'h04
`define SDRT_OFS_TIMING 8'h08
`define SDRT_OFS_MODE 8'h0c
`define SDRT_OFS_STATUS 8'h10

// refresh_enable_reg
`define SDRT_REFEN_BIT 0
// refresh_control_reg
`define SDRT_RFC_MSB 11
`define SDRT_RFC_LSB 0
`define SDRT_REFRESH_WAIT_CYCLES_MSB 15
`define SDRT_REFRESH_WAIT_CYCLES_LSB 12
// access_timing_reg
`define SDRT_CL_MSB 2
`define SDRT_CL_LSB 0
`define SDRT_WR_BIT 8
`define SDRT_RP_MSB 11
`define SDRT_RP_LSB 9
`define SDRT_RCD_MSB 13
`define SDRT_RCD_LSB 12
`define SDRT_RAS_MSB 18
`define SDRT_RAS_LSB 16
// mode_write_reg: low 12 bits on the address pins, next 2 on bank pins
`define SDRT_MODE_MSB 14

// reset values
`define SDRT_RST_REFEN 1'h0
`define SDRT_RST_REFCTL 16'h33a7
`define SDRT_RST_TIMING 19'h21303
`define SDRT_RST_MODE 15'h0230

// wait after a mode register set, in sdram clock cycles
`define SDRT_MRD_CYCLES 5'h02

// sdram command codes {cs_n, ras_n, cas_n, we_n}
`define SDRT_CMD_DSL 4'hf
`define SDRT_CMD_MRS 4'h0
`define SDRT_CMD_REF 4'h1
`define SDRT_CMD_ACT 4'h3
`define SDRT_CMD_RD 4'h5
`define SDRT_CMD_WR 4'h4
`define SDRT_CMD_PRE 4'h2

// axi responses
`define SDRT_RESP_OKAY 2'h0
`define SDRT_RESP_SLVERR 2'h2

`endif

/* hdl/sdrt_refresh_timer.v */
// Purpose: periodic auto-refresh due generator
// Assumes: tick marks one sdram clock cycle
// Notes: due is a one-clk pulse, held state frozen while ce is low
`timescale 1ns/1ps
module sdrt_refresh_timer (
  // clock and control
  input wire clk,
  input wire rst,
  input wire ce,
  input wire tick,
  // configuration
  input wire enable,
  input wire [11:0] interval,
  // event
  output reg due
);

reg en_d_r;
reg [11:0] cnt_r;

always @(posedge clk or posedge rst) begin
  if (rst) begin
    en_d_r <= 1'b0;
    cnt_r <= 12'h000;
    due <= 1'b0;
  end else if (ce) begin
    due <= 1'b0;
    if (tick) begin
      en_d_r <= enable;
      if (enable && !en_d_r) begin
        due <= 1'b1;
        cnt_r <= interval;
      end else if (enable) begin
        // period is interval + 1 cycles
        if (cnt_r == 12'h000) begin
          due <= 1'b1;
          cnt_r <= interval;
        end else begin
          cnt_r <= cnt_r - 12'h001;
        end
      end
    end
  end
end

endmodule

/* dv/sdrt_mem_model.sv */
// Purpose: behavioural single-data-rate sdram for the bench
// Assumes: burst length one, commands sampled on sd_clk rise
// Notes: the data bus toggles whenever no read answer drives it
`timescale 1ns/1ps
`include "sdrt_map.vh"
module sdrt_mem_model #(
  parameter int CL = 3
) (
  // sdram command pins
  input wire sd_clk,
  input wire sd_cs_n,
  input wire sd_ras_n,
  input wire sd_cas_n,
  input wire sd_we_n,
  input wire [1:0] sd_ba,
  input wire [11:0] sd_addr,
  // data
  input wire [15:0] sd_dq_out,
  input wire sd_dq_oe,
  output logic [15:0] sd_dq_in
);
  logic [15:0] mem [int];
  logic [11:0] row_r [4];
  logic [15:0] word_r;
  int cnt = 0;
  wire [3:0] cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
  wire [21:0] key = {sd_ba, row_r[sd_ba], sd_addr[7:0]};
  initial sd_dq_in = 16'h0;
  always @(posedge sd_clk) begin
    // a stale word must never look like a late answer
    sd_dq_in <= (cnt == 1) ? word_r : ~sd_dq_in;
    if (cmd == `SDRT_CMD_ACT)
      row_r[sd_ba] <= sd_addr;
    if (cmd == `SDRT_CMD_WR)
      mem[key] = sd_dq_oe ? sd_dq_out : ~sd_dq_out;
    if (cmd == `SDRT_CMD_RD) begin
      word_r <= mem.exists(key) ? mem[key] : 16'h0;
      cnt <= CL;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

/* dv/sdrt_ctrl_asserts.sv */
// Purpose: timing checks on the sdram command pins
// Assumes: timing fields and refresh wait keep their reset values
// Notes: a command starts in the clk cycle where sd_clk reads low
`timescale 1ns/1ps
`include "sdrt_map.vh"
module sdrt_ctrl_asserts (
  // clock and reset
  input wire clk,
  input wire rst,
  // sdram pins
  input wire sd_clk,
  input wire sd_cs_n,
  input wire sd_ras_n,
  input wire sd_cas_n,
  input wire sd_we_n,
  input wire [11:0] sd_addr,
  // read paths
  input wire rd_valid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid
);
  wire [3:0] cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
  wire st = !sd_clk;
  reg open_r;
  always @(posedge clk or posedge rst) begin
    if (rst)
      open_r <= 1'h0;
    else if (cmd == `SDRT_CMD_ACT)
      open_r <= 1'h1;
    else if (cmd == `SDRT_CMD_PRE)
      open_r <= 1'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ref_wait:
    assert property (st && cmd == `SDRT_CMD_REF |->
      ##2 (cmd == `SDRT_CMD_DSL) [*8]) else $error("refresh wait short");
  a_act_cmd:
    assert property (st && cmd == `SDRT_CMD_ACT |-> ##2
      (cmd == `SDRT_CMD_DSL) [*2] ##1
      (cmd == `SDRT_CMD_RD || cmd == `SDRT_CMD_WR))
      else $error("activate to command wrong");
  a_wr_pre:
    assert property (st && cmd == `SDRT_CMD_WR |-> ##2
      (cmd == `SDRT_CMD_DSL) [*2] ##1 cmd == `SDRT_CMD_PRE)
      else $error("write recovery wrong");
  a_rd_data:
    assert property (st && cmd == `SDRT_CMD_RD |-> ##[9:11] rd_valid)
      else $error("read latency wrong");
  a_rd_pre:
    assert property (st && cmd == `SDRT_CMD_RD |->
      ##[12:13] cmd == `SDRT_CMD_PRE) else $error("read not closed");
  a_pre_wait:
    assert property (st && cmd == `SDRT_CMD_PRE |->
      ##2 (cmd == `SDRT_CMD_DSL) [*4]) else $error("precharge wait short");
  a_pre_all:
    assert property (cmd == `SDRT_CMD_PRE |-> sd_addr[10])
      else $error("precharge not all banks");
  a_ref_closed:
    assert property (cmd == `SDRT_CMD_REF |-> !open_r)
      else $error("refresh inside access");
  a_mrs_wait:
    assert property (st && cmd == `SDRT_CMD_MRS |->
      ##2 (cmd == `SDRT_CMD_DSL) [*4]) else $error("mode wait short");
  a_axi_read:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
  c_ref: cover property (st && cmd == `SDRT_CMD_REF);
  c_mrs: cover property (st && cmd == `SDRT_CMD_MRS);
  c_read: cover property (rd_valid);
endmodule

/* dv/sdrt_ctrl_bench.sv */
// Purpose: self-checking bench for the refresh and timing controller
// Assumes: timing fields and refresh wait stay at reset values
// Notes: sd_clk comes from the design itself; ce drops once mid-run
`timescale 1ns/1ps
`include "sdrt_map.vh"
module sdrt_ctrl_bench;
  logic clk = 1'h0, rst = 1'h1, ce = 1'h1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, req_valid = 1'h0, req_write = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [21:0] req_addr = 22'h0;
  logic [15:0] req_wdata = 16'h0;
  wire awready, wready, bvalid, arready, rvalid, req_ack, rd_valid;
  wire sd_clk, cs_n, ras_n, cas_n, we_n, dq_oe, cke;
  wire [1:0] bresp, rresp, ba, dqm;
  wire [31:0] rdata;
  wire [15:0] rd_data, dq_in, dq_out;
  wire [11:0] addr;
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  int err_total = 0, num_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  sdrt_ctrl sdrt_ctrl_i (.clk(clk), .rst(rst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ack(req_ack), .rd_valid(rd_valid), .rd_data(rd_data),
    .sd_clk(sd_clk), .sd_cke(cke), .sd_cs_n(cs_n), .sd_ras_n(ras_n),
    .sd_cas_n(cas_n), .sd_we_n(we_n), .sd_ba(ba), .sd_addr(addr),
    .sd_dqm(dqm), .sd_dq_in(dq_in), .sd_dq_out(dq_out), .sd_dq_oe(dq_oe));
  sdrt_mem_model #(.CL(3)) mem_i (.sd_clk(sd_clk), .sd_cs_n(cs_n),
    .sd_ras_n(ras_n), .sd_cas_n(cas_n), .sd_we_n(we_n), .sd_ba(ba),
    .sd_addr(addr), .sd_dq_out(dq_out), .sd_dq_oe(dq_oe), .sd_dq_in(dq_in));
  task automatic close_out;
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk("bresp", a > 8'h10 ? 2'h2 : 2'h0, bresp);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk("rdata", e, rdata);
    chk("rresp", a > 8'h10 ? 2'h2 : 2'h0, rresp);
  endtask
  // counts clk edges until the command is first seen
  task automatic wcmd(input logic [3:0] c, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmd !== c);
  endtask
  task automatic gap(output int n);
    int m;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmd === `SDRT_CMD_REF);
    wcmd(`SDRT_CMD_REF, m);
    n = n + m;
  endtask
  task automatic acc(input logic w, input logic [21:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    req_valid <= 1'h1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do @(posedge clk); while (!req_ack);
    req_valid <= 1'h0;
    q = 16'h0;
    if (!w) begin
      do @(posedge clk); while (!rd_valid);
      q = rd_data;
    end
  endtask
  task automatic t_regs;
    logic [7:0] a [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] v [6] = '{32'h0, 32'h33a7, 32'h21303, 32'h230, 32'h0,
                           32'h0};
    for (int i = 0; i < 6; i++)
      axr(a[i], v[i]);
    axw(8'h14, 32'hffff);
    chk("cke", 32'h1, cke);
    chk("dqm", 32'h0, dqm);
    // only the low byte lane may change
    wstrb <= 4'h1;
    axw(`SDRT_OFS_REFCTL, 32'hffffff55);
    wstrb <= 4'hf;
    axr(`SDRT_OFS_REFCTL, 32'h3355);
  endtask
  task automatic t_mode;
    int n;
    // bank bits differ from reset so a stale word cannot pass
    axw(`SDRT_OFS_MODE, 32'h2230);
    wcmd(`SDRT_CMD_MRS, n);
    chk("mode wait", 1, n < 20);
    chk("mode word", 32'h2230, {ba, addr});
  endtask
  task automatic t_ref;
    int n;
    // interval 13h gives 20 sdram cycles, 40 clk
    axw(`SDRT_OFS_REFCTL, 32'h3013);
    axw(`SDRT_OFS_REFEN, 32'h1);
    wcmd(`SDRT_CMD_REF, n);
    chk("first refresh", 1, n < 8);
    gap(n);
    for (int i = 0; i < 2; i++) begin
      gap(n);
      chk("refresh period", 40, n);
    end
    // ten frozen clk edges stretch the period by exactly ten
    repeat (3) @(posedge clk);
    ce <= 1'h0;
    repeat (10) @(posedge clk);
    ce <= 1'h1;
    wcmd(`SDRT_CMD_REF, n);
    chk("frozen period", 50, n + 13);
  endtask
  // refresh keeps running so some fall due inside an access
  task automatic t_acc;
    logic [21:0] a [3] = '{22'h000000, 22'h3fffff, 22'h2a5a5a};
    logic [15:0] q;
    axw(`SDRT_OFS_TIMING, 32'h21303);
    for (int i = 0; i < 3; i++)
      acc(1'h1, a[i], a[i][15:0] ^ 16'h5a0f, q);
    for (int i = 0; i < 3; i++) begin
      acc(1'h0, a[i], 16'h0, q);
      chk("read data", a[i][15:0] ^ 16'h5a0f, q);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    t_regs();
    t_mode();
    t_ref();
    t_acc();
    close_out();
  end
endmodule
bind sdrt_ctrl sdrt_ctrl_asserts chk_i (.clk(clk), .rst(rst),
  .sd_clk(sd_clk), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n),
  .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n), .sd_addr(sd_addr),
  .rd_valid(rd_valid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
